/* File: rtl/rac_map.vh */
`ifndef RAC_MAP_VH
`define RAC_MAP_VH
// ************************************************************
// Register offsets
// ************************************************************
`define RAC_OFF_CTRL        12'h000
`define RAC_OFF_ALARM_TIME  12'h004
`define RAC_OFF_ALARM_DATE  12'h008
`define RAC_OFF_NOW_TIME    12'h00c
`define RAC_OFF_NOW_DATE    12'h010
`define RAC_OFF_IRQ_STATUS  12'h014
`define RAC_OFF_IRQ_MASK    12'h018
// ************************************************************
// Alarm control fields
// ************************************************************
`define RAC_BIT_ARM         15
`define RAC_BIT_WRAP        14
`define RAC_BIT_PSL         13
`define RAC_BIT_UNSAFE      12
`define RAC_PER_HI          11
`define RAC_PER_LO          8
`define RAC_CNT_HI          7
`define RAC_CNT_LO          0
`define RAC_CTRL_RESET      32'h0000_0000
// ************************************************************
// Match periods
// ************************************************************
`define RAC_PER_HALF        4'h0
`define RAC_PER_SEC         4'h1
`define RAC_PER_10SEC       4'h2
`define RAC_PER_MIN         4'h3
`define RAC_PER_10MIN       4'h4
`define RAC_PER_HOUR        4'h5
`define RAC_PER_DAY         4'h6
`define RAC_PER_WEEK        4'h7
`define RAC_PER_MONTH       4'h8
`define RAC_PER_YEAR        4'h9
// ************************************************************
// Interrupt bits and timing
// ************************************************************
`define RAC_IRQ_EVENT       0
`define RAC_IRQ_DISARM      1
`define RAC_IRQ_W           2
`define RAC_GUARD_CYC       6'd32
`define RAC_MATCH_W         6
`endif

/* File: rtl/rac_field_match.v */
`timescale 1ns/1ps
module rac_field_match #(
	parameter W = 8
) (
	input  wire [W-1:0] now_val,
	input  wire [W-1:0] alarm_val,
	input  wire         masked,
	output wire         hit
);
	assign hit = masked | (now_val == alarm_val);
endmodule // rac_field_match

/* File: rtl/rac_alarm_ctrl.v */
`timescale 1ns/1ps
`include "rac_map.vh"
// What this block does
// (R1) Alarm events only while alarm_arm set.
// (R2) Wrap enabled: countdown 00 wraps to ff.
// (R3) Wrap disabled: countdown halts at 00.
// (R4) Disarmed: pulse start level writable, sets pulse.
// (R5) Armed: start level ignores writes, reads pulse.
// (R6) Read-unsafe flag set near half-second rollover.
// (R7) Software rereads countdown until two reads agree.
// (R8) Flag clears only beyond 32 cycles from rollover.
// (R9) Match period code selects alarm interval.
// (R10) Yearly on February 29 fires every four years.
// (R11) Software never programs reserved period codes.
// (R12) Event at 00 without wrap clears arm.
// (R13) Software avoids alarm writes while running and unsafe.
// (R14) Software reads complete within 32 bus cycles.
// (R15) Control bits 31 to 16 read zero.
// (R16) Countdown decrements on every alarm event above 00.
// (R17) Countdown N yields N plus one alarms.
// (R18) Event when unmasked time and date fields match.
// (R19) Pulse starts at start level, toggles per event.
module rac_alarm_ctrl (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        half_sec_tick,
	input  wire [5:0]  ticks_to_half,
	input  wire        rtc_enable,
	input  wire [31:0] now_time,
	input  wire [31:0] now_date,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	output reg         alarm_pulse,
	output reg         alarm_event,
	output wire        irq
);
	// ************************************************************
	// Registers
	// ************************************************************
	reg        arm_r;
	reg        wrap_r;
	reg        psl_r;
	reg        unsafe_r;
	reg  [3:0] period_r;
	reg  [7:0] count_r;
	reg        half_r;
	reg [31:0] al_time_r;
	reg [31:0] al_date_r;
	reg [`RAC_IRQ_W-1:0] status_r;
	reg [`RAC_IRQ_W-1:0] mask_r;
	reg [31:0] rdata_nxt;
	wire       wr_en;
	wire       addr_ok;
	wire       ctrl_wr;
	wire [`RAC_MATCH_W-1:0] msk;
	wire [`RAC_MATCH_W-1:0] hit;
	wire [6:0] min_keep;
	wire [12:0] date_keep;
	wire       leap_ok;
	wire       fire;
	wire       disarm;
	// ************************************************************
	// APB slave
	// ************************************************************
	// Single-cycle access phase keeps every read well inside the safe window.
	assign pready  = 1'b1;
	assign wr_en   = psel & penable & pwrite;
	assign addr_ok = (paddr == `RAC_OFF_CTRL) | (paddr == `RAC_OFF_ALARM_TIME) |
		(paddr == `RAC_OFF_ALARM_DATE) | (paddr == `RAC_OFF_NOW_TIME) |
		(paddr == `RAC_OFF_NOW_DATE) | (paddr == `RAC_OFF_IRQ_STATUS) |
		(paddr == `RAC_OFF_IRQ_MASK);
	assign pslverr = psel & penable & ~addr_ok;
	assign ctrl_wr = wr_en & (paddr == `RAC_OFF_CTRL);
	// ************************************************************
	// Match logic
	// ************************************************************
	// Fields: 0 sub-second, 1 seconds ones, 2 seconds tens+minutes,
	// 3 hours, 4 weekday, 5 day and month.
	assign msk[0] = 1'b0;
	assign msk[1] = (period_r == `RAC_PER_HALF) | (period_r == `RAC_PER_SEC);
	assign msk[2] = (period_r <= `RAC_PER_10SEC);
	// Minute tens count from hourly up, minute ones from ten-minutely up.
	assign min_keep = {{3{period_r >= `RAC_PER_HOUR}}, {4{period_r >= `RAC_PER_10MIN}}};
	// The month only counts for the yearly period, on both sides alike.
	assign date_keep = {((period_r == `RAC_PER_YEAR) ? 5'h1f : 5'h00), 8'hff};
	assign msk[3] = (period_r <= `RAC_PER_HOUR);
	assign msk[4] = (period_r != `RAC_PER_WEEK);
	assign msk[5] = (period_r <= `RAC_PER_WEEK);
	rac_field_match #(.W(1)) u_m0 (
		.now_val   (half_r),
		.alarm_val (1'b1),
		.masked    (period_r == `RAC_PER_HALF),
		.hit       (hit[0])
	); // R9
	rac_field_match #(.W(4)) u_m1 (
		.now_val   (now_time[11:8]),
		.alarm_val (al_time_r[11:8]),
		.masked    (msk[1]),
		.hit       (hit[1])
	); // R18
	rac_field_match #(.W(11)) u_m2 (
		.now_val   ({now_time[22:16] & min_keep, now_time[14:12], 1'b0}),
		.alarm_val ({al_time_r[22:16] & min_keep, al_time_r[14:12], 1'b0}),
		.masked    (msk[2]),
		.hit       (hit[2])
	); // R18
	rac_field_match #(.W(6)) u_m3 (
		.now_val   (now_time[29:24]),
		.alarm_val (al_time_r[29:24]),
		.masked    (msk[3]),
		.hit       (hit[3])
	); // R18
	rac_field_match #(.W(3)) u_m4 (
		.now_val   (now_date[2:0]),
		.alarm_val (al_date_r[2:0]),
		.masked    (msk[4]),
		.hit       (hit[4])
	); // R9
	rac_field_match #(.W(13)) u_m5 (
		.now_val   ({now_date[20:16], now_date[13:8], 2'b00} & date_keep),
		.alarm_val ({al_date_r[20:16], al_date_r[13:8], 2'b00} & date_keep),
		.masked    (msk[5]),
		.hit       (hit[5])
	); // R9
	// Year digits in BCD: a multiple of four has an even tens digit with
	// ones 0, 4, 8 or an odd tens digit with ones 2, 6.
	assign leap_ok = ~((period_r == `RAC_PER_YEAR) && (al_date_r[20:8] == 13'h0229)) |
		(now_date[28] ? (now_date[27:24] == 4'h2 || now_date[27:24] == 4'h6)
		: (now_date[27:24] == 4'h0 || now_date[27:24] == 4'h4 ||
		now_date[27:24] == 4'h8)); // R10
	// Periods from one second up also need the sub-second, and from ten seconds up the second, to line up.
	// A control write in the same cycle wins, so the event is dropped there.
	assign fire = arm_r & ~ctrl_wr & half_sec_tick & (&hit) & leap_ok &
		((period_r == `RAC_PER_HALF) | half_r |
		(period_r != `RAC_PER_HALF & half_r)) &
		((period_r < `RAC_PER_10SEC) | (now_time[11:8] == al_time_r[11:8])); // R1
	assign disarm = fire & (count_r == 8'h00) & ~wrap_r; // R12
	// ************************************************************
	// Timekeeping-side state
	// ************************************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			arm_r       <= 1'b0;
			wrap_r      <= 1'b0;
			psl_r       <= 1'b0;
			period_r    <= 4'h0;
			count_r     <= 8'h00;
			half_r      <= 1'b0;
			unsafe_r    <= 1'b0;
			alarm_pulse <= 1'b0;
			alarm_event <= 1'b0;
			al_time_r   <= 32'h0000_0000;
			al_date_r   <= 32'h0000_0000;
		end else begin
			alarm_event <= fire;
			if (half_sec_tick) begin
				half_r <= ~half_r;
			end
			unsafe_r <= (ticks_to_half <= `RAC_GUARD_CYC); // R6 R8
			if (ctrl_wr) begin
				wrap_r   <= pwdata[`RAC_BIT_WRAP];
				period_r <= pwdata[`RAC_PER_HI:`RAC_PER_LO];
				count_r  <= pwdata[`RAC_CNT_HI:`RAC_CNT_LO];
				arm_r    <= pwdata[`RAC_BIT_ARM];
				if (!arm_r) begin
					psl_r       <= pwdata[`RAC_BIT_PSL]; // R4
					alarm_pulse <= pwdata[`RAC_BIT_PSL]; // R19
				end
			end else if (fire) begin
				alarm_pulse <= ~alarm_pulse; // R19
				if (count_r != 8'h00) begin
					count_r <= count_r - 8'h01; // R16 R17
				end else if (wrap_r) begin
					count_r <= 8'hff; // R2
				end // R3
				if (disarm) begin
					arm_r <= 1'b0; // R12
				end
			end
			if (wr_en && paddr == `RAC_OFF_ALARM_TIME) begin
				al_time_r <= pwdata;
			end
			if (wr_en && paddr == `RAC_OFF_ALARM_DATE) begin
				al_date_r <= pwdata;
			end
		end
	end
	// ************************************************************
	// Interrupts
	// ************************************************************
	always @(posedge clk) begin
		if (!rst_n) begin
			status_r <= {`RAC_IRQ_W{1'b0}};
			mask_r   <= {`RAC_IRQ_W{1'b0}};
		end else begin
			// A new event beats a simultaneous write-one clear.
			status_r <= (status_r & ~((wr_en && paddr == `RAC_OFF_IRQ_STATUS) ?
				pwdata[`RAC_IRQ_W-1:0] : {`RAC_IRQ_W{1'b0}})) |
				{disarm, fire};
			if (wr_en && paddr == `RAC_OFF_IRQ_MASK) begin
				mask_r <= pwdata[`RAC_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(status_r & mask_r);
	// ************************************************************
	// Read data
	// ************************************************************
	always @* begin
		rdata_nxt = 32'h0000_0000; // R15
		case (paddr)
			`RAC_OFF_CTRL: begin
				rdata_nxt[`RAC_BIT_ARM]    = arm_r;
				rdata_nxt[`RAC_BIT_WRAP]   = wrap_r;
				rdata_nxt[`RAC_BIT_PSL]    = arm_r ? alarm_pulse : psl_r; // R5
				rdata_nxt[`RAC_BIT_UNSAFE] = unsafe_r; // R6
				rdata_nxt[`RAC_PER_HI:`RAC_PER_LO] = period_r;
				rdata_nxt[`RAC_CNT_HI:`RAC_CNT_LO] = count_r;
			end
			`RAC_OFF_ALARM_TIME: rdata_nxt = al_time_r;
			`RAC_OFF_ALARM_DATE: rdata_nxt = al_date_r;
			`RAC_OFF_NOW_TIME:   rdata_nxt = now_time;
			`RAC_OFF_NOW_DATE:   rdata_nxt = now_date;
			`RAC_OFF_IRQ_STATUS: rdata_nxt = {30'h0, status_r};
			`RAC_OFF_IRQ_MASK:   rdata_nxt = {30'h0, mask_r};
			default:             rdata_nxt = 32'h0000_0000;
		endcase
	end
	// Read data is registered in the setup cycle and shown in the access cycle.
	always @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_nxt;
		end
	end
endmodule // rac_alarm_ctrl

/* File: test/rac_alarm_ctrl_asserts.sv */
`timescale 1ns/1ps
`include "rac_map.vh"
// ****************************************
// Port checks
// ****************************************
module rac_alarm_ctrl_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        half_sec_tick,
	input wire logic [5:0]  ticks_to_half,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        alarm_pulse,
	input wire logic        alarm_event
);
	wire rd_c = psel && penable && !pwrite && paddr == `RAC_OFF_CTRL;
	wire wr_c = psel && penable && pwrite && pready && paddr == `RAC_OFF_CTRL;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	ev_once_a: assert property (alarm_event |=> !alarm_event)
		else $error("event wider than one cycle");
	ev_tick_a: assert property (alarm_event |-> $past(half_sec_tick))
		else $error("event without rollover");
	pulse_cause_a: assert property ($changed(alarm_pulse) |->
		alarm_event || $past(psel && penable && pwrite)) else $error("pulse moved alone");
	hi_zero_a: assert property (rd_c |-> prdata[31:16] == 16'h0)
		else $error("upper control bits set");
	unsafe_set_a: assert property (rd_c && $past(ticks_to_half) <= 6'd32 &&
		$past(ticks_to_half, 2) <= 6'd32 |-> prdata[12]) else $error("flag not set");
	unsafe_clr_a: assert property (rd_c && $past(ticks_to_half) > 6'd32 &&
		$past(ticks_to_half, 2) > 6'd32 |-> !prdata[12]) else $error("flag not clear");
	pulse_read_a: assert property (rd_c && prdata[15] && $stable(alarm_pulse) |->
		prdata[13] == alarm_pulse) else $error("level read wrong");
	disarm_quiet_a: assert property (wr_c && !pwdata[15] |=> !alarm_event [*3])
		else $error("event while disarmed");
endmodule // rac_alarm_ctrl_chk
bind rac_alarm_ctrl rac_alarm_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n),
	.half_sec_tick(half_sec_tick), .ticks_to_half(ticks_to_half), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .alarm_pulse(alarm_pulse), .alarm_event(alarm_event));

/* File: test/rac_alarm_ctrl_tb.sv */
`timescale 1ns/1ps
`include "rac_map.vh"
// ****************************************
// Bench
// ****************************************
module rac_alarm_ctrl_tb;
	reg         clk, rst_n, half_sec_tick, rtc_enable, psel, penable, pwrite, e;
	reg  [5:0]  ticks_to_half;
	reg  [11:0] paddr;
	reg  [31:0] now_time, now_date, pwdata, d;
	wire        pready, pslverr, alarm_pulse, alarm_event, irq;
	wire [31:0] prdata;
	integer     err_total, n_compared, n;
	rac_alarm_ctrl u_dut (.clk(clk), .rst_n(rst_n), .half_sec_tick(half_sec_tick),
		.ticks_to_half(ticks_to_half), .rtc_enable(rtc_enable), .now_time(now_time),
		.now_date(now_date), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.alarm_pulse(alarm_pulse), .alarm_event(alarm_event), .irq(irq));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// The request stays up until pready is seen high at a rising edge.
	task xfer(input w, input [11:0] a, input [31:0] wd);
		begin
			@(posedge clk);
			{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			while (pready !== 1'b1) @(posedge clk);
			d = prdata;
			e = pslverr;
			{psel, penable} <= 2'b00;
		end
	endtask
	task tick;
		begin
			@(posedge clk);
			half_sec_tick <= 1'b1;
			@(posedge clk);
			half_sec_tick <= 1'b0;
			n = 0;
			repeat (3) begin
				@(posedge clk);
				if (alarm_event === 1'b1) n = n + 1;
			end
		end
	endtask
	task test_count;
		begin
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d, `RAC_CTRL_RESET);
			xfer(0, 12'h0fc, 0);
			chk({31'h0, e}, 32'h1);
			xfer(1, `RAC_OFF_IRQ_MASK, 32'h1);
			xfer(1, `RAC_OFF_CTRL, 32'h8001);
			tick; chk(n, 1);
			chk({31'h0, irq}, 32'h1);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d, 32'ha000);
			xfer(1, `RAC_OFF_IRQ_STATUS, 32'h1);
			@(posedge clk);
			chk({31'h0, irq}, 32'h0);
			tick; chk(n, 1);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d, 32'h0);
			tick; chk(n, 0);
			xfer(1, `RAC_OFF_CTRL, 32'hc000);
			tick; chk(n, 1);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d, 32'he0ff);
			$display("count test end");
		end
	endtask
	task test_level;
		begin
			xfer(1, `RAC_OFF_CTRL, 32'h0);
			xfer(1, `RAC_OFF_CTRL, 32'h2000);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d, 32'h2000);
			xfer(1, `RAC_OFF_CTRL, 32'ha001);
			@(posedge clk);
			chk({31'h0, alarm_pulse}, 32'h1);
			tick; chk({31'h0, alarm_pulse}, 32'h0);
			xfer(1, `RAC_OFF_CTRL, 32'ha005);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d, 32'h8005);
			$display("level test end");
		end
	endtask
	task test_flag_period;
		begin
			ticks_to_half <= 6'd32;
			repeat (2) @(posedge clk);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk({31'h0, d[12]}, 32'h1);
			n = d[7:0];
			xfer(0, `RAC_OFF_CTRL, 0);
			chk(d[7:0], n);
			ticks_to_half <= 6'd33;
			repeat (2) @(posedge clk);
			xfer(0, `RAC_OFF_CTRL, 0);
			chk({31'h0, d[12]}, 32'h0);
			xfer(1, `RAC_OFF_ALARM_TIME, 32'h0);
			now_time <= 32'h0000_0500;
			xfer(1, `RAC_OFF_CTRL, 32'h8300);
			tick; chk(n, 0);
			now_time <= 32'h0;
			// Coarse periods fire on one half of the second only.
			tick; d = n; tick; chk(d + n, 1);
			xfer(1, `RAC_OFF_ALARM_DATE, 32'h0002_2900);
			now_date <= 32'h2102_2900;
			xfer(1, `RAC_OFF_CTRL, 32'h8900);
			tick; d = n; tick; chk(d + n, 0);
			now_date <= 32'h2402_2900;
			tick; d = n; tick; chk(d + n, 1);
			$display("flag and period test end");
		end
	endtask
	task finish_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run needs about 150 cycles, so this limit only trips on a hang.
	initial begin
		#100000;
		err_total = err_total + 1;
		finish_test;
	end
	initial begin
		{rst_n, half_sec_tick, psel, penable, pwrite, paddr, pwdata} = 0;
		{now_time, now_date, err_total, n_compared} = 0;
		rtc_enable = 1'b1;
		ticks_to_half = 6'h3f;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		test_count;
		test_level;
		test_flag_period;
		finish_test;
	end
endmodule // rac_alarm_ctrl_tb
